// >>> iepr_core_model.sv
// Model of the core sequencer and the peripheral pending flags
`timescale 1ns/1ns
module iepr_core_model (
  input wire logic sys_clk,
  input wire logic [17:0] flags_in,
  input wire logic [1:0] svc_in,
  output iepr_pkg::iepr_pend_type pend,
  output logic in_service_low,
  output logic in_service_high
);
  import iepr_pkg::*;
  // ----
  // Flags and service levels move at the falling edge
  // ----
  always @(negedge sys_clk) begin
    pend <= iepr_pend_type'(flags_in);
    in_service_low <= svc_in[0];
    in_service_high <= svc_in[1];
  end
endmodule

// >>> iepr_pkg.sv
// Shared constants and carrier types for the interrupt enable and priority registers
package iepr_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IEPR_ADDR_ENABLE_MAIN = 8'hA8;
  localparam logic [7:0] IEPR_ADDR_PRIORITY_MAIN = 8'hB8;
  localparam logic [7:0] IEPR_ADDR_ENABLE_EXT_FIRST = 8'hE6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IEPR_RST_ENABLE_MAIN = 8'h00;
  localparam logic [6:0] IEPR_RST_PRIORITY_MAIN = 7'h00;
  localparam logic [7:0] IEPR_RST_ENABLE_EXT_FIRST = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IEPR_BIT_GLOBAL_GATE = 7;
  localparam int IEPR_BIT_PRIO_UNUSED = 7;
  localparam int IEPR_BIT_EXT_RESERVED = 1;
  localparam int IEPR_NUM_MAIN_SRC = 7;
  localparam int IEPR_EXT_VEC_OFFSET = 7;

  // ----------------------------------------------------------------
  // Vector numbers in fixed arbitration order
  // ----------------------------------------------------------------
  localparam int IEPR_NUM_VEC = 15;
  localparam int IEPR_VEC_W = 4;
  localparam int IEPR_VEC_EXT0 = 0;
  localparam int IEPR_VEC_TMR0 = 1;
  localparam int IEPR_VEC_EXT1 = 2;
  localparam int IEPR_VEC_TMR1 = 3;
  localparam int IEPR_VEC_SER_PORT = 4;
  localparam int IEPR_VEC_TMR2 = 5;
  localparam int IEPR_VEC_SER_PERIPH = 6;
  localparam int IEPR_VEC_SMBUS = 7;
  localparam int IEPR_VEC_RSVD = 8;
  localparam int IEPR_VEC_WIN = 9;
  localparam int IEPR_VEC_CONV = 10;
  localparam int IEPR_VEC_PCA = 11;
  localparam int IEPR_VEC_CMP0 = 12;
  localparam int IEPR_VEC_CMP1 = 13;
  localparam int IEPR_VEC_TMR3 = 14;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ext_irq_zero_input;
    logic timer_zero_overflow_flag;
    logic ext_irq_one_input;
    logic timer_one_overflow_flag;
    logic serial_port_zero_pend;
    logic timer_two_low_overflow_flag;
    logic timer_two_high_overflow_flag;
    logic serial_periph_pend;
    logic smbus_zero_pend;
    logic window_compare_flag;
    logic conversion_done_flag;
    logic counter_array_pend;
    logic comparator_zero_rise_flag;
    logic comparator_zero_fall_flag;
    logic comparator_one_rise_flag;
    logic comparator_one_fall_flag;
    logic timer_three_low_overflow_flag;
    logic timer_three_high_overflow_flag;
  } iepr_pend_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] bit_addr;
    logic bit_wval;
    logic bit_wr;
    logic bit_rd;
  } iepr_sfr_req_type;

endpackage

// >>> iepr_top.sv
// Interrupt enable and priority registers with request gating and arbitration
`timescale 1ns/1ns

// Behaviour
// - Global gate cleared blocks every source regardless of its mask bit.
// - Global gate set passes each source according to its own mask bit.
// - Main enable bit 6 gates all serial peripheral unit zero requests.
// - Main enable bit 5 gates timer two low or high overflow requests.
// - Main enable bit 4 gates the serial port zero request.
// - Main enable bit 3 gates the timer one overflow request.
// - Main enable bit 2 gates external interrupt one requests.
// - Main enable bit 1 gates the timer zero overflow request.
// - Main enable bit 0 gates external interrupt zero requests.
// - Main priority top bit always reads one; writes to it are ignored.
// - Priority bits 6..0 set level of the seven main sources; one is high.
// - Extended enable bit 7 gates timer three low or high overflow requests.
// - Extended enable bit 6 gates comparator one rise or fall requests.
// - Extended enable bit 5 gates comparator zero rise or fall requests.
// - Extended enable bit 4 gates all counter array requests.
// - Extended enable bit 3 gates the conversion complete request.
// - Extended enable bit 2 gates the window compare request.
// - Extended enable bit 1 reads zero; software writes zero there.
// - Extended enable bit 0 gates all smbus unit zero requests.
// - All three registers answer on every page; first two are bit addressable.
// - High level may preempt a low routine; a high routine is never preempted.
// - Higher level wins; equal levels resolve by lowest vector number.
module iepr_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire iepr_pkg::iepr_sfr_req_type sfr_req,
  input wire iepr_pkg::iepr_pend_type pend,
  input wire logic in_service_low,
  input wire logic in_service_high,
  output logic [7:0] sfr_rdata,
  output logic sfr_bit_rdata,
  output logic [iepr_pkg::IEPR_NUM_VEC-1:0] irq_req,
  output logic irq_valid,
  output logic [iepr_pkg::IEPR_VEC_W-1:0] irq_vector,
  output logic irq_high
);
  import iepr_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] enable_main_q;
  logic [7:0] enable_main_d;
  logic [6:0] priority_main_q;
  logic [6:0] priority_main_d;
  logic [7:0] enable_ext_first_q;
  logic [7:0] enable_ext_first_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic bit_rdata_q;
  logic bit_rdata_d;
  logic [IEPR_NUM_VEC-1:0] req_q;
  logic valid_q;
  logic [IEPR_VEC_W-1:0] vector_q;
  logic high_q;

  // ----------------------------------------------------------------
  // Address decode, page independent
  // ----------------------------------------------------------------
  wire hit_men = sfr_req.addr == IEPR_ADDR_ENABLE_MAIN;
  wire hit_mpr = sfr_req.addr == IEPR_ADDR_PRIORITY_MAIN;
  wire hit_xen = sfr_req.addr == IEPR_ADDR_ENABLE_EXT_FIRST;
  wire bhit_men = sfr_req.bit_addr[7:3] == IEPR_ADDR_ENABLE_MAIN[7:3];
  wire bhit_mpr = sfr_req.bit_addr[7:3] == IEPR_ADDR_PRIORITY_MAIN[7:3];
  wire [2:0] bsel = sfr_req.bit_addr[2:0];

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  wire [7:0] men_view = enable_main_q;
  wire [7:0] mpr_view = {1'b1, priority_main_q};
  wire [7:0] xen_view = {enable_ext_first_q[7:2], 1'b0, enable_ext_first_q[0]};

  // ----------------------------------------------------------------
  // Bit-access write images
  // ----------------------------------------------------------------
  logic [7:0] men_bit_img;
  logic [7:0] mpr_bit_img;

  always_comb begin
    men_bit_img = men_view;
    mpr_bit_img = mpr_view;
    men_bit_img[bsel] = sfr_req.bit_wval;
    mpr_bit_img[bsel] = sfr_req.bit_wval;
  end

  // ----------------------------------------------------------------
  // Next register values
  // ----------------------------------------------------------------
  wire men_byte_wr = sfr_req.wr && hit_men;
  wire mpr_byte_wr = sfr_req.wr && hit_mpr;
  wire xen_byte_wr = sfr_req.wr && hit_xen;
  wire men_bit_wr = sfr_req.bit_wr && bhit_men;
  wire mpr_bit_wr = sfr_req.bit_wr && bhit_mpr;
  wire [7:0] xen_wdata = {sfr_req.wdata[7:2], 1'b0, sfr_req.wdata[0]};

  assign enable_main_d = men_byte_wr ? sfr_req.wdata :
                         men_bit_wr ? men_bit_img : enable_main_q;
  assign priority_main_d = mpr_byte_wr ? sfr_req.wdata[6:0] :
                           mpr_bit_wr ? mpr_bit_img[6:0] : priority_main_q;
  assign enable_ext_first_d = xen_byte_wr ? xen_wdata : enable_ext_first_q;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] rd_mux = hit_men ? men_view :
                      hit_mpr ? mpr_view :
                      hit_xen ? xen_view : 8'h00;
  wire bit_mux = bhit_men ? men_view[bsel] :
                 bhit_mpr ? mpr_view[bsel] : 1'b0;

  assign rdata_d = sfr_req.rd ? rd_mux : rdata_q;
  assign bit_rdata_d = sfr_req.bit_rd ? bit_mux : bit_rdata_q;

  // ----------------------------------------------------------------
  // Raw pending per vector
  // ----------------------------------------------------------------
  logic [IEPR_NUM_VEC-1:0] raw;

  always_comb begin
    raw = '0;
    raw[IEPR_VEC_EXT0] = pend.ext_irq_zero_input;
    raw[IEPR_VEC_TMR0] = pend.timer_zero_overflow_flag;
    raw[IEPR_VEC_EXT1] = pend.ext_irq_one_input;
    raw[IEPR_VEC_TMR1] = pend.timer_one_overflow_flag;
    raw[IEPR_VEC_SER_PORT] = pend.serial_port_zero_pend;
    raw[IEPR_VEC_TMR2] = pend.timer_two_low_overflow_flag |
                         pend.timer_two_high_overflow_flag;
    raw[IEPR_VEC_SER_PERIPH] = pend.serial_periph_pend;
    raw[IEPR_VEC_SMBUS] = pend.smbus_zero_pend;
    raw[IEPR_VEC_RSVD] = 1'b0;
    raw[IEPR_VEC_WIN] = pend.window_compare_flag;
    raw[IEPR_VEC_CONV] = pend.conversion_done_flag;
    raw[IEPR_VEC_PCA] = pend.counter_array_pend;
    raw[IEPR_VEC_CMP0] = pend.comparator_zero_rise_flag |
                         pend.comparator_zero_fall_flag;
    raw[IEPR_VEC_CMP1] = pend.comparator_one_rise_flag |
                         pend.comparator_one_fall_flag;
    raw[IEPR_VEC_TMR3] = pend.timer_three_low_overflow_flag |
                         pend.timer_three_high_overflow_flag;
  end

  // ----------------------------------------------------------------
  // Per-vector mask, level and gating
  // ----------------------------------------------------------------
  wire global_irq_gate = enable_main_q[IEPR_BIT_GLOBAL_GATE];
  logic [IEPR_NUM_VEC-1:0] mask;
  logic [IEPR_NUM_VEC-1:0] level;
  logic [IEPR_NUM_VEC-1:0] pass;

  genvar gv;
  generate
    for (gv = 0; gv < IEPR_NUM_VEC; gv = gv + 1) begin : g_vec
      if (gv < IEPR_NUM_MAIN_SRC) begin : g_main
        assign mask[gv] = enable_main_q[gv];
        assign level[gv] = priority_main_q[gv];
      end else if (gv == IEPR_VEC_RSVD) begin : g_rsvd
        assign mask[gv] = 1'b0;
        assign level[gv] = 1'b0;
      end else begin : g_ext
        assign mask[gv] = enable_ext_first_q[gv - IEPR_EXT_VEC_OFFSET];
        assign level[gv] = 1'b0;
      end
      assign pass[gv] = raw[gv] & mask[gv] & global_irq_gate;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Arbitration and preemption
  // ----------------------------------------------------------------
  function automatic logic [IEPR_VEC_W-1:0] first_set(input logic [IEPR_NUM_VEC-1:0] v);
    logic [IEPR_VEC_W-1:0] idx;
    idx = '0;
    for (int i = IEPR_NUM_VEC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IEPR_VEC_W'(i);
      end
    end
    return idx;
  endfunction

  wire [IEPR_NUM_VEC-1:0] hi_pass = pass & level;
  wire [IEPR_NUM_VEC-1:0] lo_pass = pass & ~level;
  wire any_hi = |hi_pass;
  wire any_lo = |lo_pass;
  wire allow_hi = !in_service_high;
  wire allow_lo = !in_service_high && !in_service_low;
  wire take_hi = any_hi && allow_hi;
  wire take_lo = !take_hi && any_lo && allow_lo;
  wire [IEPR_VEC_W-1:0] win_vec = take_hi ? first_set(hi_pass) : first_set(lo_pass);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      enable_main_q <= IEPR_RST_ENABLE_MAIN;
      priority_main_q <= IEPR_RST_PRIORITY_MAIN;
      enable_ext_first_q <= IEPR_RST_ENABLE_EXT_FIRST;
      rdata_q <= 8'h00;
      bit_rdata_q <= 1'b0;
    end else begin
      enable_main_q <= enable_main_d;
      priority_main_q <= priority_main_d;
      enable_ext_first_q <= enable_ext_first_d;
      rdata_q <= rdata_d;
      bit_rdata_q <= bit_rdata_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      req_q <= '0;
      valid_q <= 1'b0;
      vector_q <= '0;
      high_q <= 1'b0;
    end else begin
      req_q <= pass;
      valid_q <= take_hi || take_lo;
      vector_q <= win_vec;
      high_q <= take_hi;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata = rdata_q;
  assign sfr_bit_rdata = bit_rdata_q;
  assign irq_req = req_q;
  assign irq_valid = valid_q;
  assign irq_vector = vector_q;
  assign irq_high = high_q;

endmodule

// >>> iepr_top_checker.sv
// Assertion checker for the interrupt enable and priority registers
`timescale 1ns/1ns
module iepr_top_checker (
  input wire logic sys_clk,
  input wire logic srst,
  input wire iepr_pkg::iepr_sfr_req_type sfr_req,
  input wire iepr_pkg::iepr_pend_type pend,
  input wire logic in_service_low,
  input wire logic in_service_high,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_bit_rdata,
  input wire logic [iepr_pkg::IEPR_NUM_VEC-1:0] irq_req,
  input wire logic irq_valid,
  input wire logic [iepr_pkg::IEPR_VEC_W-1:0] irq_vector,
  input wire logic irq_high
);
  import iepr_pkg::*;
  // ----
  // Properties
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  AST_PRIO_TOP: assert property (sfr_req.rd && sfr_req.addr == 8'hB8 |=> sfr_rdata[7])
    else $error("priority top bit read zero");
  AST_PRIO_TOP_BIT: assert property (sfr_req.bit_rd && sfr_req.bit_addr == 8'hBF |=> sfr_bit_rdata)
    else $error("priority top bit read zero by bit");
  AST_EXT_RSVD: assert property (sfr_req.rd && sfr_req.addr == 8'hE6 |=> !sfr_rdata[1])
    else $error("reserved enable bit read one");
  AST_TMR0_SRC: assert property (irq_req[1] |-> $past(pend.timer_zero_overflow_flag))
    else $error("timer zero request without flag");
  AST_TMR2_SRC: assert property (
    irq_req[5] |-> $past(pend.timer_two_low_overflow_flag
    | pend.timer_two_high_overflow_flag))
    else $error("timer two request without flag");
  AST_CMP1_SRC: assert property (
    irq_req[13] |-> $past(pend.comparator_one_rise_flag
    | pend.comparator_one_fall_flag))
    else $error("comparator one request without flag");
  AST_WIN_REQ: assert property (irq_valid |-> irq_req[irq_vector])
    else $error("winner not requesting");
  AST_LOW_ORDER: assert property (
    irq_valid && !irq_high
    |-> (irq_req & ((15'h1 << irq_vector) - 15'h1)) == 15'h0)
    else $error("lower vector skipped");
  AST_HIGH_NO_PREEMPT: assert property ($past(in_service_high) |-> !irq_valid)
    else $error("high routine preempted");
  AST_LOW_PREEMPT: assert property (irq_valid && $past(in_service_low) |-> irq_high)
    else $error("low request preempted low routine");
  CVR_HIGH: cover property (irq_valid && irq_high);
  CVR_PREEMPT: cover property (irq_valid && in_service_low);
  CVR_BIT_WR: cover property (sfr_req.bit_wr);
endmodule

bind iepr_top iepr_top_checker i_chk (.sys_clk, .srst, .sfr_req, .pend, .in_service_low,
  .in_service_high, .sfr_rdata, .sfr_bit_rdata, .irq_req, .irq_valid, .irq_vector, .irq_high);

// >>> tb.sv
// Self-checking bench for the interrupt enable and priority registers
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
  import iepr_pkg::*;
  // ----
  // Bench
  // ----
  logic sys_clk = 0;
  logic srst = 1;
  iepr_sfr_req_type sfr_req = '0;
  iepr_pend_type pend;
  logic in_service_low, in_service_high, sfr_bit_rdata, irq_valid, irq_high, ev;
  logic [7:0] sfr_rdata, men, mpr, xen;
  logic [14:0] irq_req, er, hi, src;
  logic [3:0] irq_vector;
  logic [17:0] flags_in = '0;
  logic [1:0] svc_in = '0;
  logic [31:0] rs = 32'hD;
  int mismatches = 0;
  int compares = 0;
  int w;
  always #50 sys_clk = ~sys_clk;
  iepr_top i_dut (.sys_clk, .srst, .sfr_req, .pend, .in_service_low, .in_service_high,
    .sfr_rdata, .sfr_bit_rdata, .irq_req, .irq_valid, .irq_vector, .irq_high);
  iepr_core_model i_core (.sys_clk, .flags_in, .svc_in, .pend, .in_service_low,
    .in_service_high);
  function automatic void xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
  endfunction
  function automatic logic [14:0] ereq(logic [17:0] f);
    logic [14:0] r;
    r = {|f[1:0], |f[3:2], |f[5:4], f[6], f[7], f[8], 1'b0, f[9], f[10], |f[12:11], f[13],
      f[14], f[15], f[16], f[17]} & {xen[7:2], 1'b0, xen[0], men[6:0]};
    return men[7] ? r : 15'h0;
  endfunction
  task automatic acc(input iepr_sfr_req_type r);
    @(negedge sys_clk);
    sfr_req = r;
    @(negedge sys_clk);
    sfr_req = '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc('{a, d, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc('{a, 8'h00, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0, 1'b0});
    `CHK("rdata", e, sfr_rdata)
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    acc('{8'h00, 8'h00, 1'b0, 1'b0, a, v, 1'b1, 1'b0});
  endtask
  task automatic brd(input logic [7:0] a, input logic e);
    acc('{8'h00, 8'h00, 1'b0, 1'b0, a, 1'b0, 1'b0, 1'b1});
    `CHK("bit_rdata", e, sfr_bit_rdata)
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 0;
    rd(8'hA8, 8'h00);
    rd(8'hB8, 8'h80);
    rd(8'hE6, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'hB8, 8'h00);
    rd(8'hB8, 8'h80);
    wr(8'hE6, 8'hFD);
    rd(8'hE6, 8'hFD);
    bw(8'hB9, 1'b1);
    rd(8'hB8, 8'h82);
    bw(8'hAF, 1'b1);
    brd(8'hAF, 1'b1);
    brd(8'hBF, 1'b1);
    for (int i = 0; i < 300; i++) begin
      xs();
      men = (i < 2) ? {i[0], 7'h7F} : rs[7:0];
      xen = (i < 2) ? 8'hFD : rs[15:8] & 8'hFD;
      mpr = rs[23:16];
      wr(8'hA8, men);
      wr(8'hE6, xen);
      wr(8'hB8, mpr);
      rd(8'hB8, mpr | 8'h80);
      @(posedge sys_clk);
      xs();
      flags_in = (i < 2) ? '1 : rs[17:0];
      svc_in = (i < 2) ? 2'b00 : rs[21:20] & rs[23:22];
      @(negedge sys_clk);
      @(negedge sys_clk);
      er = ereq(flags_in);
      hi = er & {8'h00, mpr[6:0]};
      src = (|hi) ? hi : er;
      w = 0;
      for (int v = 14; v >= 0; v--) if (src[v]) w = v;
      ev = |er && !svc_in[1] && !(svc_in[0] && !(|hi));
      `CHK("irq_req", er, irq_req)
      `CHK("irq_valid", ev, irq_valid)
      if (ev) `CHK("irq_vector", w[3:0], irq_vector)
      if (ev) `CHK("irq_high", |hi, irq_high)
    end
    @(negedge sys_clk);
    srst = 1;
    repeat (3) @(negedge sys_clk);
    srst = 0;
    `CHK("irq_req", 15'h0000, irq_req)
    `CHK("irq_valid", 1'b0, irq_valid)
    `CHK("rdata", 8'h00, sfr_rdata)
    rd(8'hB8, 8'h80);
    rd(8'hE6, 8'h00);
    rd(8'hA8, 8'h00);
    `CHK("irq_req", 15'h0000, irq_req)
    wrap_up();
  end
endmodule
